// ==== design/pcu_params.svh ====
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH
// register byte offsets (low 16 bits of haddr are decoded)
`define PCU_OFS_CONTROL 16'h1e60
`define PCU_OFS_STATUS 16'h1e64
`define PCU_OFS_FAULT 16'h1e68
// control field positions
`define PCU_BIT_BUFSEL 16
`define PCU_BIT_ENABLE 15
`define PCU_BIT_INVAL 11
`define PCU_BIT_COHERE 10
`define PCU_BIT_INJECT 0
// status field positions
`define PCU_BIT_TAGERR 2
`define PCU_BIT_SECERR 1
`define PCU_BIT_PARERR 0
// reset values
`define PCU_RST_BUFSEL 1'b1
`define PCU_RST_ENABLE 1'b1
`define PCU_RST_COHERE 1'b1
`define PCU_RST_FAULT 8'hff
// geometry
`define PCU_LINES 128
`define PCU_SLICES 4
`define PCU_PARITY_SEL 8'h80
`endif

// ==== design/pcu_pkg.sv ====
`include "pcu_params.svh"
package pcu_pkg;
	typedef struct packed {
		logic valid;
		logic [23:0] addr;
		logic branch;
		logic no_cache;
	} pcu_fetch_req_t;
	typedef struct packed {
		logic valid;
		logic [127:0] data;
		logic bus_error;
	} pcu_fetch_rsp_t;
	typedef struct packed {
		logic [127:0] data;
		logic error;
		logic sec_error;
	} pcu_flash_rsp_t;
	typedef struct packed {
		logic valid;
		logic [23:0] addr;
		logic [127:0] data;
		logic error;
	} pcu_line_t;
	typedef enum {
		PCU_IDLE,
		PCU_FETCH,
		PCU_DROP
	} pcu_state_t;
endpackage : pcu_pkg

// ==== design/pcu_prefetch_cache.sv ====
// What this block does
// - cache is direct mapped, 128 lines, one line per address
// - each line stores 128 data bits plus one parity bit
// - parity checked on every cache read; fault injection supported
// - only instruction fetch port is served and cached
// - miss in stream buffer and cache starts a flash line fetch
// - stream buffer two deep; next sequential line prefetched
// - flow change lets running fetch finish, drops it, refetches target
// - flow change target hit in cache answers at once
// - branch-target mode caches only demand-miss lines, not prefetches, copies hit into stream buffer
// - several stream slices keep independent linear streams
// - buffer select bit 16 chooses slice 0 or 1 when disabled
// - enable bit 15 off invalidates all slices and cache
// - manual invalidate bit 11 clears everything, self clears
// - coherency bit 10 invalidates cache on flash program or erase
// - inject bit 0 arms one fault on next fetch that matches a valid cache line, self clears
// - tag read error sets status bit 2 and forces a miss
// - fetched stream word with flash error bit set sets status bit 1
// - fetched cache word with parity failure sets status bit 0
// - pointer 0-127 data bit, 128 parity bit, above flips no bit yet still raises event and invalidates line
// - parity bit is even parity over 128 data bits
// - parity error raises event, invalidates line, refetches from flash
// - pointer write while armed re-arms injection
// - vector, debug and invalid flash fetches are never cached
//
// Our own choice: the AHB-Lite slave port.
module pcu_prefetch_cache
	import pcu_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// cpu instruction fetch
	input wire pcu_fetch_req_t i_fetch,
	output pcu_fetch_rsp_t o_fetch,
	// program flash
	output logic o_flash_req,
	output logic [23:0] o_flash_addr,
	input wire logic i_flash_done,
	input wire pcu_flash_rsp_t i_flash,
	input wire logic i_flash_write_event,
	// system
	input wire logic i_tag_read_error,
	input wire logic i_branch_target_mode,
	output logic o_integrity_event
);
	// ======================================================
	// registers
	logic bufsel, enable, inval, cohere, inject;
	logic tag_err, sec_err, par_err;
	logic [7:0] fault_ptr;
	logic wr_pend, rd_pend;
	logic [15:0] wr_addr;
	logic bus_go, wr_ctl, wr_flt, auto_inval, inj_fire;
	logic [31:0] wd;
	logic par_hit_err, tag_miss;
	logic sec_take;

	assign bus_go = i_hsel && i_hready && i_htrans[1];
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign wd = i_hwdata;
	assign wr_ctl = wr_pend && wr_addr == `PCU_OFS_CONTROL;
	assign wr_flt = wr_pend && wr_addr == `PCU_OFS_FAULT;

	// zero-wait slave: address phase captured, write data used next cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_addr <= 16'h0000;
		end else begin
			wr_pend <= bus_go && i_hwrite;
			rd_pend <= bus_go && !i_hwrite;
			wr_addr <= i_haddr[15:0];
		end
	end

	// read data built from address phase so it stands in the data phase
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h00000000;
		end else if (bus_go && !i_hwrite) begin
			o_hrdata <= 32'h00000000;
			case (i_haddr[15:0])
				`PCU_OFS_CONTROL: begin
					o_hrdata[`PCU_BIT_BUFSEL] <= bufsel;
					o_hrdata[`PCU_BIT_ENABLE] <= enable;
					o_hrdata[`PCU_BIT_INVAL] <= inval;
					o_hrdata[`PCU_BIT_COHERE] <= cohere;
					o_hrdata[`PCU_BIT_INJECT] <= inject;
				end
				`PCU_OFS_STATUS: begin
					o_hrdata[`PCU_BIT_TAGERR] <= tag_err;
					o_hrdata[`PCU_BIT_SECERR] <= sec_err;
					o_hrdata[`PCU_BIT_PARERR] <= par_err;
				end
				`PCU_OFS_FAULT: o_hrdata[7:0] <= fault_ptr;
				default: o_hrdata <= 32'h00000000;
			endcase
		end
	end

	// control register plain fields
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bufsel <= `PCU_RST_BUFSEL;
			enable <= `PCU_RST_ENABLE;
			cohere <= `PCU_RST_COHERE;
			fault_ptr <= `PCU_RST_FAULT;
		end else begin
			if (wr_ctl) begin
				bufsel <= wd[`PCU_BIT_BUFSEL];
				enable <= wd[`PCU_BIT_ENABLE];
				cohere <= wd[`PCU_BIT_COHERE];
			end
			if (wr_flt) fault_ptr <= wd[7:0];
		end
	end

	// invalidation requests; invalidate is set-only by software, done in one cycle
	assign auto_inval = (cohere && i_flash_write_event) || (wr_ctl && !wd[`PCU_BIT_ENABLE]);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			inval <= 1'b0;
		end else if (wr_ctl && wd[`PCU_BIT_INVAL]) begin
			inval <= 1'b1;
		end else if (inval || auto_inval) begin
			inval <= 1'b0;
		end
	end

	// one-shot fault arm; a pointer write while armed re-arms
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			inject <= 1'b0;
		end else if ((wr_ctl && wd[`PCU_BIT_INJECT]) || (wr_flt && inject)) begin
			inject <= 1'b1;
		end else if (inj_fire) begin
			inject <= 1'b0;
		end
	end

	// ======================================================
	// cache array
	logic [127:0] c_data [`PCU_LINES];
	logic c_par [`PCU_LINES];
	logic [12:0] c_tag [`PCU_LINES];
	logic [`PCU_LINES-1:0] c_valid;
	logic [6:0] idx;
	logic [12:0] tag;
	logic c_hit, par_bad;
	logic [127:0] rd_word;
	logic rd_par;
	logic [127:0] flip;

	assign idx = i_fetch.addr[10:4];
	assign tag = i_fetch.addr[23:11];
	// injected bit is xored on the read path only
	always_comb begin
		flip = 128'h0;
		if (fault_ptr < `PCU_PARITY_SEL) flip[fault_ptr[6:0]] = inject;
	end
	assign rd_word = c_data[idx] ^ flip;
	assign rd_par = c_par[idx] ^ (inject && fault_ptr == `PCU_PARITY_SEL);
	assign par_bad = (^rd_word) != rd_par;
	assign tag_miss = i_tag_read_error;
	assign c_hit = enable && c_valid[idx] && c_tag[idx] == tag && !tag_miss;
	assign inj_fire = inject && i_fetch.valid && enable && c_valid[idx] && c_tag[idx] == tag;
	assign par_hit_err = c_hit && par_bad;

	// ======================================================
	// stream buffer: slices of two lines, round robin replacement
	pcu_line_t sb [`PCU_SLICES][2];
	logic [1:0] victim;
	logic [1:0] cur;
	logic [`PCU_SLICES-1:0] s_hit0;
	logic sb_hit;
	logic [1:0] hit_slice;
	pcu_state_t state;
	logic [23:0] fetch_addr;
	logic fetch_is_miss, fetch_nc;
	logic [23:0] line_addr;

	assign line_addr = {i_fetch.addr[23:4], 4'h0};
	genvar g;
	generate
		for (g = 0; g < `PCU_SLICES; g++) begin : g_slice
			assign s_hit0[g] = sb[g][0].valid && sb[g][0].addr == line_addr
				&& (enable || g == 32'(cur));
		end
	endgenerate
	always_comb begin
		hit_slice = 2'd0;
		for (int k = 0; k < `PCU_SLICES; k++) begin
			if (s_hit0[k]) hit_slice = k[1:0];
		end
	end
	assign sb_hit = |s_hit0;

	// the next line already waits in the second entry of the current slice;
	// it is promoted on this request, so fetching it again would waste flash time
	logic nxt_hit;
	assign nxt_hit = sb[cur][1].valid && sb[cur][1].addr == line_addr;

	// a cache hit only answers where the mode lets it; in branch-target mode a
	// sequential request that hits only the cache must still go to flash, or it hangs
	logic c_serve;
	assign c_serve = c_hit && !par_bad && (!i_branch_target_mode || i_fetch.branch);

	// ======================================================
	// fetch answers: stream buffer first, then cache
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fetch <= '0;
		end else begin
			o_fetch.valid <= 1'b0;
			if (i_fetch.valid && sb_hit) begin
				o_fetch.valid <= 1'b1;
				o_fetch.data <= sb[hit_slice][0].data;
				o_fetch.bus_error <= sb[hit_slice][0].error;
			end else if (i_fetch.valid && c_serve) begin
				o_fetch.valid <= 1'b1;
				o_fetch.data <= rd_word;
				o_fetch.bus_error <= 1'b0;
			end
		end
	end
	assign sec_take = i_fetch.valid && sb_hit && sb[hit_slice][0].error;

	// status flags: sticky, only reset clears them
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tag_err <= 1'b0;
			sec_err <= 1'b0;
			par_err <= 1'b0;
			o_integrity_event <= 1'b0;
		end else begin
			if (i_fetch.valid && i_tag_read_error) tag_err <= 1'b1;
			if (sec_take) sec_err <= 1'b1;
			if (i_fetch.valid && par_hit_err) par_err <= 1'b1;
			o_integrity_event <= (i_fetch.valid && par_hit_err) || inj_fire;
		end
	end

	// ======================================================
	// flash fetch engine
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= PCU_IDLE;
			fetch_addr <= 24'h000000;
			fetch_is_miss <= 1'b0;
			fetch_nc <= 1'b0;
			o_flash_req <= 1'b0;
			o_flash_addr <= 24'h000000;
		end else begin
			o_flash_req <= 1'b0;
			case (state)
				PCU_IDLE: begin
					// a request goes to flash only if stream slot and next slot lack it and the cache does not serve it
					if (i_fetch.valid && !sb_hit && !nxt_hit && !c_serve) begin
						state <= PCU_FETCH;
						fetch_addr <= line_addr;
						fetch_is_miss <= 1'b1;
						fetch_nc <= i_fetch.no_cache;
						o_flash_req <= 1'b1;
						o_flash_addr <= line_addr;
					end else if (!sb[cur][1].valid && sb[cur][0].valid) begin
						state <= PCU_FETCH;
						fetch_addr <= sb[cur][0].addr + 24'h000010;
						fetch_is_miss <= 1'b0;
						fetch_nc <= 1'b0;
						o_flash_req <= 1'b1;
						o_flash_addr <= sb[cur][0].addr + 24'h000010;
					end
				end
				PCU_FETCH: begin
					if (i_fetch.valid && i_fetch.branch && i_fetch.addr[23:4] != fetch_addr[23:4])
						state <= i_flash_done ? PCU_IDLE : PCU_DROP;
					else if (i_flash_done)
						state <= PCU_IDLE;
				end
				PCU_DROP: begin
					if (i_flash_done) state <= PCU_IDLE;
				end
				default: state <= PCU_IDLE;
			endcase
		end
	end

	// current slice and its refill; while enabled a demand fill or branch-mode cache copy takes a new slice, a stream hit the matching one
	logic fill;
	assign fill = state == PCU_FETCH && i_flash_done
		&& !(i_fetch.valid && i_fetch.branch && i_fetch.addr[23:4] != fetch_addr[23:4]);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sb <= '{default: '0};
			cur <= 2'd0;
			victim <= 2'd1;
		end else if (inval || auto_inval) begin
			sb <= '{default: '0};
			cur <= enable ? 2'd0 : {1'b0, bufsel};
		end else if (!enable) begin
			cur <= {1'b0, bufsel};
			if (fill) begin
				if (fetch_is_miss) sb[cur][0] <= '{1'b1, fetch_addr, i_flash.data, i_flash.error};
				else sb[cur][1] <= '{1'b1, fetch_addr, i_flash.data, i_flash.error};
			end else if (i_fetch.valid && sb[cur][1].valid
				&& line_addr == sb[cur][1].addr) begin
				sb[cur][0] <= sb[cur][1];
				sb[cur][1].valid <= 1'b0;
			end
		end else if (i_fetch.valid && i_fetch.branch && !sb_hit && c_hit && !par_bad
			&& i_branch_target_mode) begin
			sb[victim][0] <= '{1'b1, line_addr, rd_word, 1'b0};
			sb[victim][1].valid <= 1'b0;
			cur <= victim;
			victim <= victim + 2'd1;
		end else if (fill && fetch_is_miss) begin
			sb[victim][0] <= '{1'b1, fetch_addr, i_flash.data, i_flash.error};
			sb[victim][1].valid <= 1'b0;
			cur <= victim;
			victim <= victim + 2'd1;
		end else if (fill) begin
			sb[cur][1] <= '{1'b1, fetch_addr, i_flash.data, i_flash.error};
		end else if (i_fetch.valid && sb[cur][1].valid && line_addr == sb[cur][1].addr) begin
			sb[cur][0] <= sb[cur][1];
			sb[cur][1].valid <= 1'b0;
		end else if (i_fetch.valid && sb_hit) begin
			cur <= hit_slice;
		end
	end

	// cache fill and line invalidation
	logic alloc;
	assign alloc = fill && enable && !fetch_nc && !i_flash.error
		&& (!i_branch_target_mode || fetch_is_miss);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c_valid <= '0;
		end else if (inval || auto_inval || !enable) begin
			c_valid <= '0;
		end else if (i_fetch.valid && (par_hit_err || inj_fire)) begin
			c_valid[idx] <= 1'b0;
		end else if (alloc) begin
			c_valid[fetch_addr[10:4]] <= 1'b1;
		end
	end
	always_ff @(posedge i_clock) begin
		if (alloc) begin
			c_data[fetch_addr[10:4]] <= i_flash.data;
			c_par[fetch_addr[10:4]] <= ^i_flash.data;
			c_tag[fetch_addr[10:4]] <= fetch_addr[23:11];
		end
	end
	// only i_fetch reaches this unit; data-bus reads go elsewhere
endmodule : pcu_prefetch_cache

// ==== verification/pcu_flash_model.sv ====
// ==========
// flash line reader
module pcu_flash_model
	import pcu_pkg::*;
#(parameter int LATENCY = 3)
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// line request
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	// line answer
	output logic o_done,
	output pcu_flash_rsp_t o_rsp
);
	logic [23:0] addr;
	int cnt;
	// one read in flight; a request while busy is ignored
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
			addr <= '0;
		end else if (cnt == 0 && i_req) begin
			cnt <= LATENCY;
			addr <= i_addr;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	assign o_done = (cnt == 1);
	// bits 20 and 21 mark bad lines; between reads the lines show inverted junk
	assign o_rsp = o_done ? {{4{8'ha5, addr}}, addr[20], addr[21]} : {{4{8'h5a, ~addr}}, 2'b11};
endmodule : pcu_flash_model

// ==== verification/pcu_prefetch_cache_properties.sv ====
// ==========
// port checker
module pcu_cache_props
	import pcu_pkg::*;
(
	// clock, reset and bus
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic [31:0] o_hrdata,
	// fetch and flash
	input wire pcu_fetch_req_t i_fetch,
	input wire pcu_fetch_rsp_t o_fetch,
	input wire logic o_flash_req,
	input wire logic i_flash_done,
	input wire pcu_flash_rsp_t i_flash,
	input wire logic o_integrity_event
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	logic rd_phase;
	logic seen_err;
	logic mapped;
	// read address phase and decoded register hit
	assign rd_phase = i_hsel & i_hready & i_htrans[1] & !i_hwrite;
	assign mapped = i_haddr[15:0] inside {16'h1e60, 16'h1e64, 16'h1e68};
	// remembers that some flash line came back bad
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_err <= 1'b0;
		end else if (i_flash_done && i_flash.error) begin
			seen_err <= 1'b1;
		end
	end
	a_hready_high: assert property (o_hreadyout) else $error("wait state inserted");
	a_resp_okay: assert property (!o_hresp) else $error("error response");
	a_rdata_hold: assert property (!$past(rd_phase) |-> $stable(o_hrdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (rd_phase && !mapped |=> o_hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_fetch_cause: assert property (o_fetch.valid |-> $past(i_fetch.valid))
		else $error("answer without request");
	a_flash_pulse: assert property (o_flash_req |=> !o_flash_req)
		else $error("flash request held");
	a_event_pulse: assert property (o_integrity_event |=> !o_integrity_event)
		else $error("event held");
	a_err_forward: assert property (o_fetch.valid && o_fetch.bus_error |-> seen_err)
		else $error("bus error without bad line");
endmodule : pcu_cache_props
bind pcu_prefetch_cache pcu_cache_props pcu_cache_props_i (.i_clock, .i_rst_n, .i_hsel,
	.i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_fetch,
	.o_fetch, .o_flash_req, .i_flash_done, .i_flash, .o_integrity_event);

// ==== verification/test_pcu_prefetch_cache.sv ====
`include "pcu_params.svh"
// ==========
// bench top
module test_pcu_prefetch_cache
	import pcu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock, i_rst_n, hsel, hwrite, tag_err, bt_mode, wr_event;
	logic hreadyout, hresp, flash_req, done, ievt, be;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [23:0] flash_addr;
	logic [23:0] reqs[$];
	logic [127:0] d;
	pcu_fetch_req_t fetch;
	pcu_fetch_rsp_t rsp;
	pcu_flash_rsp_t frsp;
	int err_count, checks_done, ev_count, n0;
	localparam logic [31:0] CTRL = {16'h0, `PCU_OFS_CONTROL};
	localparam logic [31:0] STAT = {16'h0, `PCU_OFS_STATUS};
	localparam logic [31:0] FLT = {16'h0, `PCU_OFS_FAULT};
	initial begin
		i_clock = 0;
		forever #10 i_clock = ~i_clock;
	end
	pcu_prefetch_cache pcu_prefetch_cache_i (.i_clock, .i_rst_n, .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_fetch(fetch), .o_fetch(rsp), .o_flash_req(flash_req),
		.o_flash_addr(flash_addr), .i_flash_done(done), .i_flash(frsp),
		.i_flash_write_event(wr_event), .i_tag_read_error(tag_err),
		.i_branch_target_mode(bt_mode), .o_integrity_event(ievt));
	pcu_flash_model pcu_flash_model_i (.i_clock, .i_rst_n, .i_req(flash_req),
		.i_addr(flash_addr), .o_done(done), .o_rsp(frsp));
	// log of flash requests and events, read before the edge updates land
	always @(posedge i_clock) begin
		if (flash_req) reqs.push_back(flash_addr);
		if (ievt) ev_count++;
	end
	task chk(input logic [127:0] got, input logic [127:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer; hready is waited for in both phases
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clock);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
		do @(posedge i_clock); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		do @(posedge i_clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(v, exp);
	endtask : rd_chk
	task wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] v;
		bus(1'b1, a, wd, v);
	endtask : wr
	// request held until the answer pulse, looked at mid-cycle
	task do_fetch(input logic [23:0] a, input logic br);
		int n;
		n = 0;
		@(posedge i_clock);
		fetch <= '{1'b1, a, br, 1'b0};
		do begin
			@(negedge i_clock);
			n++;
		end while (rsp.valid !== 1'b1 && n < 200);
		chk(n < 200, 1'b1);
		d = rsp.data;
		be = rsp.bus_error;
		@(posedge i_clock);
		fetch <= '0;
	endtask : do_fetch
	function automatic logic [127:0] pat(input logic [23:0] a);
		return {4{8'ha5, a}};
	endfunction : pat
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#1000000;
		err_count++;
		print_verdict;
	end
	initial begin
		{i_rst_n, hsel, hwrite, tag_err, bt_mode, wr_event} = '0;
		{htrans, haddr, hwdata} = '0;
		fetch = '0;
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd_chk(CTRL, 32'h00018400);
		rd_chk(STAT, 32'h0);
		rd_chk(FLT, 32'h000000ff);
		rd_chk(32'h00001e6c, 32'h0);
		$display("reset values done");
		n0 = reqs.size();
		do_fetch(24'h000100, 1'b1);
		chk(reqs[n0], 24'h000100);
		chk(d, pat(24'h000100));
		chk(be, 1'b0);
		repeat (10) @(posedge i_clock);
		do_fetch(24'h000110, 1'b0);
		chk(reqs[n0+1], 24'h000110);
		chk(d, pat(24'h000110));
		do_fetch(24'h000100, 1'b1);
		chk(d, pat(24'h000100));
		$display("miss, prefetch and hit done");
		do_fetch(24'h300000, 1'b1);
		chk(be, 1'b1);
		rd_chk(STAT, 32'h2);
		tag_err <= 1'b1;
		do_fetch(24'h000100, 1'b1);
		tag_err <= 1'b0;
		rd_chk(STAT, 32'h6);
		$display("error flags done");
		wr(CTRL, 32'h00018401);
		wr(FLT, 32'h5);
		n0 = ev_count;
		do_fetch(24'h000100, 1'b1);
		repeat (4) @(posedge i_clock);
		chk(ev_count - n0, 1);
		rd_chk(STAT, 32'h7);
		rd_chk(CTRL, 32'h00018400);
		$display("fault injection done");
		wr(CTRL, 32'h00018c00);
		rd_chk(CTRL, 32'h00018400);
		n0 = reqs.size();
		do_fetch(24'h000100, 1'b1);
		chk(reqs[n0], 24'h000100);
		wr(CTRL, 32'h00010400);
		rd_chk(CTRL, 32'h00010400);
		do_fetch(24'h000200, 1'b1);
		chk(d, pat(24'h000200));
		wr(CTRL, 32'h00000400);
		rd_chk(CTRL, 32'h00000400);
		$display("invalidate and disable done");
		wr(CTRL, 32'h00018400);
		do_fetch(24'h000400, 1'b1);
		repeat (10) @(posedge i_clock);
		wr_event <= 1'b1;
		@(posedge i_clock);
		wr_event <= 1'b0;
		n0 = reqs.size();
		do_fetch(24'h000400, 1'b1);
		chk(reqs[n0], 24'h000400);
		chk(d, pat(24'h000400));
		$display("coherency done");
		print_verdict;
	end
endmodule : test_pcu_prefetch_cache
